// *** pkg/wdcfg_params.svh ***
`ifndef WDCFG_PARAMS_SVH
`define WDCFG_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IDX_OP_STATUS 10'h035
`define IDX_WD_STATUS_A 10'h03A
`define IDX_WD_STATUS_B 10'h03B
`define IDX_HB_PREDIV 10'h03C
`define IDX_HB_TIMER 10'h03D
`define IDX_CFG_A 10'h040
`define IDX_CFG_B 10'h041
`define IDX_CFG_C 10'h042

// ****************************************
// Bus geometry
// ****************************************
`define AXI_ADDR_W 12
`define AXI_DATA_W 32
`define AXI_STRB_W 4

// ****************************************
// Reset values and writable masks
// ****************************************
`define CFG_A_RESET 8'hFF
`define CFG_B_RESET 8'h3F
`define CFG_C_RESET 8'h3F
`define CFG_A_MASK 8'hFF
`define CFG_B_MASK 8'h3F
`define CFG_C_MASK 8'hFF
`define STATUS_RESET 8'h00

// ****************************************
// Field positions
// ****************************************
`define LOCK_BIT 7
`define PP0_HI 7
`define PP0_LO 6
`define CFG_C_OL_HI 5

// ****************************************
// Config write slots
// ****************************************
`define SLOT_CFG_A 0
`define SLOT_CFG_B 1
`define SLOT_CFG_C 2
`define CFG_SLOTS 3

`endif

// *** pkg/wdcfg_pkg.sv ***
`include "wdcfg_params.svh"

package wdcfg_pkg;

  typedef enum logic [3:0]
  {
    SEL_NONE = 4'h0,
    SEL_OP_STATUS = 4'h1,
    SEL_WD_STATUS_A = 4'h2,
    SEL_WD_STATUS_B = 4'h3,
    SEL_HB_PREDIV = 4'h4,
    SEL_HB_TIMER = 4'h5,
    SEL_CFG_A = 4'h6,
    SEL_CFG_B = 4'h7,
    SEL_CFG_C = 4'h8
  } reg_sel_e;

  typedef enum logic [1:0]
  {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

  typedef logic [7:0] reg_byte_t;

endpackage : wdcfg_pkg

// *** pkg/cfg_bus_if.sv ***
`timescale 1ns/1ps
`include "wdcfg_params.svh"

interface cfg_bus_if;
  logic [`CFG_SLOTS-1:0] wr_sel;
  logic [7:0] wr_data;
  logic lock;

  modport bank
  (
    output wr_sel,
    output wr_data,
    output lock
  );

  modport target
  (
    input wr_sel,
    input wr_data,
    input lock
  );
endinterface : cfg_bus_if

// *** core/cfg_register.sv ***
`timescale 1ns/1ps
`include "wdcfg_params.svh"

module cfg_register
  import wdcfg_pkg::*;
#(
  parameter int unsigned SLOT = 0,
  parameter reg_byte_t RESET_VAL = 8'h00,
  parameter reg_byte_t WR_MASK = 8'hFF
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Write side
  cfg_bus_if.target bus,
  // Stored value
  output reg_byte_t value
);

  reg_byte_t value_reg;
  reg_byte_t value_next;

  // ****************************************
  // Lockable storage
  // ****************************************
  always_comb
  begin
    value_next = value_reg;
    if (bus.wr_sel[SLOT] && !bus.lock)
    begin
      value_next = bus.wr_data & WR_MASK; // RL1 RL14
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      value_reg <= RESET_VAL;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_CFG_LOCK_HOLD: assert property (bus.lock |=> value == $past(value)) // RL1
    else $error("config register changed while locked");

  AST_CFG_RESERVED_ZERO: assert property ((value & ~WR_MASK) == 8'h00) // RL14
    else $error("reserved config bits not zero");

endmodule : cfg_register

// *** core/status_sampler.sv ***
`timescale 1ns/1ps
`include "wdcfg_params.svh"

module status_sampler
  import wdcfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watchdog counters
  input wire logic [2:0] window_wd_powerdown_count,
  input wire logic [2:0] reset_event_count,
  input wire logic [2:0] total_error_powerdown_count,
  input wire logic [2:0] functional_wd_powerdown_count,
  // Heartbeat sampling
  input wire logic heartbeat_sample_stb,
  input wire logic [3:0] heartbeat_predivider,
  input wire logic [6:0] heartbeat_timer,
  // Status bytes
  output reg_byte_t status_a,
  output reg_byte_t status_b,
  output reg_byte_t prediv_sample,
  output reg_byte_t timer_sample
);

  reg_byte_t status_a_reg;
  reg_byte_t status_a_next;
  reg_byte_t status_b_reg;
  reg_byte_t status_b_next;
  reg_byte_t prediv_reg;
  reg_byte_t prediv_next;
  reg_byte_t timer_reg;
  reg_byte_t timer_next;

  // ****************************************
  // Status capture
  // ****************************************
  always_comb
  begin
    status_a_next = {2'b00, window_wd_powerdown_count, reset_event_count}; // RL8
    status_b_next = {2'b00, total_error_powerdown_count, functional_wd_powerdown_count}; // RL9 RL10
    prediv_next = prediv_reg;
    timer_next = timer_reg;
    if (heartbeat_sample_stb)
    begin
      prediv_next = {4'h0, heartbeat_predivider}; // RL11
      timer_next = {1'b0, heartbeat_timer}; // RL12
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_a_reg <= `STATUS_RESET;
      status_b_reg <= `STATUS_RESET;
      prediv_reg <= `STATUS_RESET;
      timer_reg <= `STATUS_RESET;
    end
    else
    begin
      status_a_reg <= status_a_next;
      status_b_reg <= status_b_next;
      prediv_reg <= prediv_next;
      timer_reg <= timer_next;
    end
  end

  assign status_a = status_a_reg;
  assign status_b = status_b_reg;
  assign prediv_sample = prediv_reg;
  assign timer_sample = timer_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_HB_HOLD: assert property (!heartbeat_sample_stb |=> $stable(timer_sample) // RL11 RL12
    && $stable(prediv_sample))
    else $error("heartbeat sample moved without strobe");

  AST_STATUS_UPPER_ZERO: assert property (status_a[7:6] == 2'b00 // RL9
    && status_b[7:6] == 2'b00 && timer_sample[7] == 1'b0)
    else $error("reserved status bits not zero");

endmodule : status_sampler

// *** core/watchdog_cfg_bank.sv ***
`timescale 1ns/1ps
`include "wdcfg_params.svh"

// Operation
// RL1: Lock set blocks all output config changes.
// RL2: Open-load bit 0 disables pull-down; resets 1.
// RL3: Overcurrent bit 0 limits, 1 switches off.
// RL4: Config C bits 7:6 pick threshold.
// RL5: Config A holds outputs 4..1 pairs, FF.
// RL6: Config B holds outputs 7..5, resets 3F.
// RL7: Config C holds open-load for outputs 13..8.
// RL8: Status A: window and reset counters.
// RL9: Status B bits 5:3 total-error counter.
// RL10: Status B bits 2:0 functional counter.
// RL11: Read-only sampled heartbeat predivider, four bits.
// RL12: Read-only sampled heartbeat timer, seven bits.
// RL13: Lock status reads at bit 7.
// RL14: Locked or read-only writes ignored silently.

module watchdog_cfg_bank
  import wdcfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [`AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [`AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [`AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Lock and watchdog state
  input wire logic cfg_lock,
  input wire logic [2:0] window_wd_powerdown_count,
  input wire logic [2:0] reset_event_count,
  input wire logic [2:0] total_error_powerdown_count,
  input wire logic [2:0] functional_wd_powerdown_count,
  input wire logic heartbeat_sample_stb,
  input wire logic [3:0] heartbeat_predivider,
  input wire logic [6:0] heartbeat_timer,
  // Output configuration
  output logic [12:0] openload_setup,
  output logic [6:0] overcurrent_setup,
  output logic [1:0] pushpull_pair0_diag_threshold
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic reg_sel_e decode_sel(input logic [`AXI_ADDR_W-1:0] addr);
    reg_sel_e sel;
    case (addr[`AXI_ADDR_W-1:2])
      `IDX_OP_STATUS: sel = SEL_OP_STATUS;
      `IDX_WD_STATUS_A: sel = SEL_WD_STATUS_A;
      `IDX_WD_STATUS_B: sel = SEL_WD_STATUS_B;
      `IDX_HB_PREDIV: sel = SEL_HB_PREDIV;
      `IDX_HB_TIMER: sel = SEL_HB_TIMER;
      `IDX_CFG_A: sel = SEL_CFG_A;
      `IDX_CFG_B: sel = SEL_CFG_B;
      `IDX_CFG_C: sel = SEL_CFG_C;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode_sel

  reg_byte_t cfg_a;
  reg_byte_t cfg_b;
  reg_byte_t cfg_c;
  reg_byte_t status_a;
  reg_byte_t status_b;
  reg_byte_t prediv_sample;
  reg_byte_t timer_sample;

  logic aw_hold_reg;
  logic aw_hold_next;
  logic [`AXI_ADDR_W-1:0] aw_addr_reg;
  logic [`AXI_ADDR_W-1:0] aw_addr_next;
  logic w_hold_reg;
  logic w_hold_next;
  reg_byte_t w_data_reg;
  reg_byte_t w_data_next;
  logic w_strb0_reg;
  logic w_strb0_next;
  logic bvalid_reg;
  logic bvalid_next;
  axi_resp_e bresp_reg;
  axi_resp_e bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [`AXI_DATA_W-1:0] rdata_reg;
  logic [`AXI_DATA_W-1:0] rdata_next;
  axi_resp_e rresp_reg;
  axi_resp_e rresp_next;

  logic wr_fire;
  logic rd_take;
  logic cfg_wr;
  reg_sel_e wr_target;
  reg_sel_e rd_target;

  cfg_bus_if cfg_bus();

  // ****************************************
  // Write channel
  // ****************************************
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_target = decode_sel(aw_addr_reg);

  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_strb0_next = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_target == SEL_NONE) ? RESP_SLVERR : RESP_OKAY; // RL14
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb0_reg <= w_strb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ****************************************
  // Config registers
  // ****************************************
  assign cfg_wr = wr_fire && w_strb0_reg;
  assign cfg_bus.wr_sel[`SLOT_CFG_A] = cfg_wr && (wr_target == SEL_CFG_A);
  assign cfg_bus.wr_sel[`SLOT_CFG_B] = cfg_wr && (wr_target == SEL_CFG_B);
  assign cfg_bus.wr_sel[`SLOT_CFG_C] = cfg_wr && (wr_target == SEL_CFG_C);
  assign cfg_bus.wr_data = w_data_reg;
  assign cfg_bus.lock = cfg_lock; // RL1

  cfg_register #(.SLOT(`SLOT_CFG_A), .RESET_VAL(`CFG_A_RESET), .WR_MASK(`CFG_A_MASK))
    u_cfg_a (.ref_clk(ref_clk), .rstn(rstn), .bus(cfg_bus), .value(cfg_a)); // RL5
  cfg_register #(.SLOT(`SLOT_CFG_B), .RESET_VAL(`CFG_B_RESET), .WR_MASK(`CFG_B_MASK))
    u_cfg_b (.ref_clk(ref_clk), .rstn(rstn), .bus(cfg_bus), .value(cfg_b)); // RL6
  cfg_register #(.SLOT(`SLOT_CFG_C), .RESET_VAL(`CFG_C_RESET), .WR_MASK(`CFG_C_MASK))
    u_cfg_c (.ref_clk(ref_clk), .rstn(rstn), .bus(cfg_bus), .value(cfg_c)); // RL7

  // Per-output setup bits, index 0 is output 1
  assign openload_setup = {cfg_c[`CFG_C_OL_HI:0], cfg_b[5], cfg_b[3], cfg_b[1],
    cfg_a[7], cfg_a[5], cfg_a[3], cfg_a[1]}; // RL2 RL7
  assign overcurrent_setup = {cfg_b[4], cfg_b[2], cfg_b[0],
    cfg_a[6], cfg_a[4], cfg_a[2], cfg_a[0]}; // RL3
  assign pushpull_pair0_diag_threshold = cfg_c[`PP0_HI:`PP0_LO]; // RL4

  // ****************************************
  // Status capture
  // ****************************************
  status_sampler u_status
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .window_wd_powerdown_count(window_wd_powerdown_count),
    .reset_event_count(reset_event_count),
    .total_error_powerdown_count(total_error_powerdown_count),
    .functional_wd_powerdown_count(functional_wd_powerdown_count),
    .heartbeat_sample_stb(heartbeat_sample_stb),
    .heartbeat_predivider(heartbeat_predivider),
    .heartbeat_timer(heartbeat_timer),
    .status_a(status_a),
    .status_b(status_b),
    .prediv_sample(prediv_sample),
    .timer_sample(timer_sample)
  );

  // ****************************************
  // Read channel
  // ****************************************
  assign s_axi_arready = !rvalid_reg;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_target = decode_sel(s_axi_araddr);

  always_comb
  begin
    reg_byte_t rd_byte;
    rd_byte = 8'h00;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rd_target)
      SEL_OP_STATUS: rd_byte[`LOCK_BIT] = cfg_lock; // RL13
      SEL_WD_STATUS_A: rd_byte = status_a; // RL8
      SEL_WD_STATUS_B: rd_byte = status_b; // RL9 RL10
      SEL_HB_PREDIV: rd_byte = prediv_sample; // RL11
      SEL_HB_TIMER: rd_byte = timer_sample; // RL12
      SEL_CFG_A: rd_byte = cfg_a;
      SEL_CFG_B: rd_byte = cfg_b;
      SEL_CFG_C: rd_byte = cfg_c;
      default: rd_byte = 8'h00;
    endcase
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    if (rd_take)
    begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_byte};
      rresp_next = (rd_target == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_LOCK_FREEZE: assert property ((wr_fire && cfg_lock) |=> cfg_a == $past(cfg_a) // RL1
    && cfg_b == $past(cfg_b) && cfg_c == $past(cfg_c))
    else $error("config changed by locked write");

  AST_OPENLOAD_WRITE: assert property ((cfg_wr && !cfg_lock && wr_target == SEL_CFG_A) // RL2
    |=> openload_setup[3:0] == {w_data_reg[7], w_data_reg[5], w_data_reg[3], w_data_reg[1]})
    else $error("open-load setup not taken from write");

  AST_OVERCURRENT_WRITE: assert property ((cfg_wr && !cfg_lock && wr_target == SEL_CFG_A) // RL3
    |=> overcurrent_setup[3:0] == {w_data_reg[6], w_data_reg[4], w_data_reg[2], w_data_reg[0]})
    else $error("overcurrent setup not taken from write");

  AST_THRESHOLD_WRITE: assert property ((cfg_wr && !cfg_lock && wr_target == SEL_CFG_C) // RL4
    |=> pushpull_pair0_diag_threshold == w_data_reg[7:6] && openload_setup[12:7] == w_data_reg[5:0])
    else $error("config C fields not taken from write");

  AST_READ_CFG_A: assert property ((rd_take && rd_target == SEL_CFG_A) // RL5
    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(cfg_a)})
    else $error("config A readback wrong");

  AST_READ_CFG_B: assert property ((rd_take && rd_target == SEL_CFG_B) // RL6
    |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0000000)
    else $error("config B reserved bits not zero");

  AST_READ_STATUS_A: assert property ((rd_take && rd_target == SEL_WD_STATUS_A) // RL8
    |=> s_axi_rdata == {24'h000000, $past(status_a)} && s_axi_rresp == RESP_OKAY)
    else $error("status A readback wrong");

  AST_READ_STATUS_B: assert property ((rd_take && rd_target == SEL_WD_STATUS_B) // RL9 RL10
    |=> s_axi_rdata == {24'h000000, $past(status_b)})
    else $error("status B readback wrong");

  AST_READ_HEARTBEAT: assert property ((rd_take && rd_target == SEL_HB_TIMER) // RL12
    |=> s_axi_rdata == {24'h000000, $past(timer_sample)} && s_axi_rdata[7] == 1'b0)
    else $error("heartbeat timer readback wrong");

  AST_READ_PREDIV: assert property ((rd_take && rd_target == SEL_HB_PREDIV) // RL11
    |=> s_axi_rdata[31:4] == 28'h0000000)
    else $error("predivider readback upper bits set");

  AST_READ_LOCK: assert property ((rd_take && rd_target == SEL_OP_STATUS) // RL13
    |=> s_axi_rdata == {24'h000000, $past(cfg_lock), 7'h00})
    else $error("lock status readback wrong");

  AST_SILENT_DISCARD: assert property ((wr_fire && wr_target != SEL_NONE) // RL14
    |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered OKAY");

  AST_BRESP_HOLD: assert property ((s_axi_bvalid && !s_axi_bready)
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

endmodule : watchdog_cfg_bank

// *** testbench/watchdog_cfg_bank_tb_top.sv ***
`timescale 1ns/1ps
`include "wdcfg_params.svh"

module watchdog_cfg_bank_tb_top
  import wdcfg_pkg::*;
;
  // ********
  // Signals
  // ********
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [`AXI_ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [`AXI_DATA_W-1:0] s_axi_wdata = '0;
  logic [`AXI_STRB_W-1:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [`AXI_ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [`AXI_DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic cfg_lock = 1'b0;
  logic [2:0] wwd_cnt = '0;
  logic [2:0] rst_cnt = '0;
  logic [2:0] tec_cnt = '0;
  logic [2:0] fwd_cnt = '0;
  logic hb_stb = 1'b0;
  logic [3:0] hb_pre = '0;
  logic [6:0] hb_tmr = '0;
  logic [12:0] openload_setup;
  logic [6:0] overcurrent_setup;
  logic [1:0] pushpull_pair0_diag_threshold;
  logic [31:0] seed = 32'h00003B81;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] m_cfg [3] = '{8'hFF, 8'h3F, 8'h3F};
  logic [7:0] m_pre = 8'h00;
  logic [7:0] m_tmr = 8'h00;
  logic [9:0] idx_list [8] = '{`IDX_OP_STATUS, `IDX_WD_STATUS_A, `IDX_WD_STATUS_B,
    `IDX_HB_PREDIV, `IDX_HB_TIMER, `IDX_CFG_A, `IDX_CFG_B, `IDX_CFG_C};

  always #50 ref_clk = ~ref_clk;

  watchdog_cfg_bank dut
  (
    .ref_clk(ref_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cfg_lock(cfg_lock),
    .window_wd_powerdown_count(wwd_cnt), .reset_event_count(rst_cnt),
    .total_error_powerdown_count(tec_cnt), .functional_wd_powerdown_count(fwd_cnt),
    .heartbeat_sample_stb(hb_stb), .heartbeat_predivider(hb_pre), .heartbeat_timer(hb_tmr),
    .openload_setup(openload_setup), .overcurrent_setup(overcurrent_setup),
    .pushpull_pair0_diag_threshold(pushpull_pair0_diag_threshold)
  );

  // ********
  // Model and helpers
  // ********
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : ba

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a[11:2])
      `IDX_OP_STATUS: return {24'h000000, cfg_lock, 7'h00};
      `IDX_WD_STATUS_A: return {26'h0000000, wwd_cnt, rst_cnt};
      `IDX_WD_STATUS_B: return {26'h0000000, tec_cnt, fwd_cnt};
      `IDX_HB_PREDIV: return {24'h000000, m_pre};
      `IDX_HB_TIMER: return {24'h000000, m_tmr};
      `IDX_CFG_A: return {24'h000000, m_cfg[0]};
      `IDX_CFG_B: return {24'h000000, m_cfg[1]};
      `IDX_CFG_C: return {24'h000000, m_cfg[2]};
      default: return 32'h00000000;
    endcase
  endfunction : exp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    int t;
    aw_ok = 0;
    w_ok = 0;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok) && t < 50)
    begin
      @(posedge ref_clk);
      t++;
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (!s_axi_bvalid && t < 50);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
    if (er === RESP_OKAY && !cfg_lock && st[0])
    begin
      if (a[11:2] == `IDX_CFG_A) m_cfg[0] = d;
      if (a[11:2] == `IDX_CFG_B) m_cfg[1] = d & 8'h3F;
      if (a[11:2] == `IDX_CFG_C) m_cfg[2] = d;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (!s_axi_arready && t < 50);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (!s_axi_rvalid && t < 100);
    s_axi_rready <= 1'b0;
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
    chk(s_axi_rdata, exp_rd(a));
    // Let an edge pass so a following read does not raise rready in this step
    @(posedge ref_clk);
  endtask : rd

  task automatic chk_ports();
    logic [12:0] ol;
    logic [6:0] oc;
    for (int k = 0; k < 4; k++)
    begin
      ol[k] = m_cfg[0][2*k+1];
      oc[k] = m_cfg[0][2*k];
    end
    for (int k = 0; k < 3; k++)
    begin
      ol[4+k] = m_cfg[1][2*k+1];
      oc[4+k] = m_cfg[1][2*k];
    end
    ol[12:7] = m_cfg[2][5:0];
    chk({19'h0, openload_setup}, {19'h0, ol});
    chk({25'h0, overcurrent_setup}, {25'h0, oc});
    chk({30'h0, pushpull_pair0_diag_threshold}, {30'h0, m_cfg[2][7:6]});
  endtask : chk_ports

  task automatic check_all();
    for (int k = 0; k < 8; k++)
      rd(ba(idx_list[k]), RESP_OKAY);
    chk_ports();
  endtask : check_all

  task automatic end_test(input string name);
    $display("Test %s done, checks %0d, mismatches %0d", name, n_checks, err_total);
  endtask : end_test

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ********
  // Tests
  // ********
  initial
  begin
    logic [31:0] r;
    logic [11:0] a;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check_all();
    end_test("reset");
    repeat (24)
    begin
      r = rnd();
      a = ba(`IDX_CFG_A + 10'(r[9:8] % 3));
      wr(a, r[7:0], 4'hF, RESP_OKAY);
      chk_ports();
      rd(a, RESP_OKAY);
    end
    end_test("config");
    for (int c = 0; c < 4; c++)
    begin
      wr(ba(`IDX_CFG_C), {c[1:0], 6'h2A}, 4'h1, RESP_OKAY);
      chk_ports();
    end
    wr(ba(`IDX_CFG_A), ~m_cfg[0], 4'hE, RESP_OKAY);
    check_all();
    end_test("threshold");
    cfg_lock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(ba(`IDX_OP_STATUS), RESP_OKAY);
    for (int k = 0; k < 3; k++)
      wr(ba(idx_list[5+k]), ~m_cfg[k], 4'hF, RESP_OKAY);
    check_all();
    cfg_lock <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wr(ba(`IDX_CFG_B), 8'hC5, 4'hF, RESP_OKAY);
    check_all();
    end_test("lock");
    for (int k = 0; k < 5; k++)
      wr(ba(idx_list[k]), 8'hFF, 4'hF, RESP_OKAY);
    wr(12'hFFC, 8'h00, 4'hF, RESP_SLVERR);
    rd(12'hFFC, RESP_SLVERR);
    check_all();
    end_test("readonly");
    repeat (6)
    begin
      r = rnd();
      {wwd_cnt, rst_cnt, tec_cnt, fwd_cnt} <= r[11:0];
      repeat (2) @(posedge ref_clk);
      check_all();
    end
    end_test("counters");
    repeat (4)
    begin
      r = rnd();
      hb_pre <= r[3:0];
      hb_tmr <= r[10:4];
      hb_stb <= 1'b1;
      @(posedge ref_clk);
      hb_stb <= 1'b0;
      hb_pre <= ~r[3:0];
      hb_tmr <= ~r[10:4];
      m_pre = {4'h0, r[3:0]};
      m_tmr = {1'b0, r[10:4]};
      repeat (2) @(posedge ref_clk);
      rd(ba(`IDX_HB_PREDIV), RESP_OKAY);
      rd(ba(`IDX_HB_TIMER), RESP_OKAY);
    end
    end_test("heartbeat");
    summarize();
  end

  // ********
  // Watchdog
  // ********
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    summarize();
  end
endmodule : watchdog_cfg_bank_tb_top
